// ===== logic/adcsp_pkg.sv
// shared constants and types of the converter serial host port
package adcsp_pkg;

  // ----------------------------------------------------------------
  // word and buffer shape
  // ----------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h18;
  localparam int FIFO_DEPTH = 32;

  // ----------------------------------------------------------------
  // timing: system clock, nominal master clock, self-clock phases
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int MCLK_NS = 100;
  localparam int SCK_HI_NS = 100;
  localparam int SCK_LO_NS = 300;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] SCK_HI_CYC = DIV_W'((SCK_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [DIV_W-1:0] SCK_LO_CYC = DIV_W'((SCK_LO_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // synchronised pin positions
  // ----------------------------------------------------------------
  localparam int PIN_N = 6;
  localparam int PIN_MODE = 5;
  localparam int PIN_SEL = 4;
  localparam int PIN_RFS = 3;
  localparam int PIN_TFS = 2;
  localparam int PIN_SCK = 1;
  localparam int PIN_DIN = 0;

  // ----------------------------------------------------------------
  // transfer state, Gray along idle-read-done; done-idle flips both bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_DONE = 2'h3,
    ST_WRITE = 2'h2
  } adcsp_state_t;

  // word written by the host, with its target
  typedef struct packed {
    logic to_data_cal;
    logic [WORD_W-1:0] word;
  } adcsp_wr_t;

endpackage

// ===== logic/adcsp_fifo.sv
// result buffer between the converter core and the serial port
`timescale 1ns/10ps
`default_nettype none
module adcsp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;

  // ----------------------------------------------------------------
  // flags: extra pointer bit tells full from empty
  // ----------------------------------------------------------------
  assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer next values
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ===== logic/adcsp_port.sv
// serial host port with self and external clocking and register select
// What this block does
// - clocking select high: self-clocking, device drives the serial clock pin
// - self-clocking: serial clock toggles only after a strobe goes low
// - self-clocking: clock pin released when strobe rises or word completes
// - clocking select low: serial clock pin is only an input
// - external clocking: continuous or gated host clock both accepted
// - register select low: transfers address the control register
// - register select high: transfers address data or calibration registers
// - after a result word is read, result ready goes high on a falling edge
`timescale 1ns/10ps
`default_nettype none
module adcsp_port import adcsp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_select,
  input wire logic register_select,
  input wire logic receive_frame_strobe_n,
  input wire logic transmit_frame_strobe_n,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe_n,
  output logic result_ready_n,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [WORD_W-1:0] res_word,
  input wire logic [WORD_W-1:0] ctrl_word,
  output logic wr_valid,
  output adcsp_wr_t wr
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_sync_n;
  logic [PIN_N-1:0] pins_raw, sync1, sync2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_q[1];

  assign pins_raw = {clock_select, register_select, receive_frame_strobe_n,
                     transmit_frame_strobe_n, sclk_in, sdata_in};

  // strobes idle high so the reset value does not start a frame
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic mode_self, sel, rfs_n_s, tfs_n_s, sck_ext, din;
  assign mode_self = sync2[PIN_MODE];
  assign sel = sync2[PIN_SEL];
  assign rfs_n_s = sync2[PIN_RFS];
  assign tfs_n_s = sync2[PIN_TFS];
  assign sck_ext = sync2[PIN_SCK];
  assign din = sync2[PIN_DIN];

  // ----------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------
  logic fifo_valid, res_pop;
  logic [WORD_W-1:0] fifo_word;

  adcsp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_word),
    .out_valid(fifo_valid),
    .out_ready(res_pop),
    .out_data(fifo_word)
  );

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  adcsp_state_t state, next_state;
  logic [WORD_W-1:0] shreg, next_shreg;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [DIV_W-1:0] div, next_div;
  logic int_sck, next_int_sck, sck_prev, sck_lvl, sck_rise, sck_fall;
  logic sel_frame, next_sel_frame, next_sdata_out, next_ready_n;
  logic next_wr_valid, active, word_done;
  adcsp_wr_t next_wr;

  // one edge detector serves both clocking modes
  assign sck_lvl = mode_self ? int_sck : sck_ext;
  assign sck_rise = sck_lvl && !sck_prev;
  assign sck_fall = !sck_lvl && sck_prev;
  assign active = (state == ST_READ) || (state == ST_WRITE);
  assign word_done = (state == ST_READ) && sck_fall && (cnt == WORD_BITS);
  assign res_pop = word_done && sel_frame && fifo_valid;

  // next values; edges only advance the count, so gated clocks just pause
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt = cnt;
    next_div = div;
    next_int_sck = int_sck;
    next_sel_frame = sel_frame;
    next_sdata_out = sdata_out;
    next_wr_valid = 1'b0;
    next_wr = wr;
    // a pop forces one high cycle, so the host sees every word consumed
    next_ready_n = !fifo_valid || res_pop;
    case (state)
      ST_IDLE: begin
        next_int_sck = 1'b1;
        next_div = '0;
        next_cnt = '0;
        next_sel_frame = sel;
        if (!rfs_n_s) begin
          // data register when selected, else control register
          next_shreg = sel ? (fifo_valid ? fifo_word : '0) : ctrl_word;
          next_sdata_out = next_shreg[WORD_W-1];
          next_state = ST_READ;
        end else if (!tfs_n_s) begin
          next_state = ST_WRITE;
        end
      end
      ST_READ, ST_WRITE: begin
        // self clock: high and low phases from a small divider
        if (mode_self) begin
          if (div == '0) begin
            next_int_sck = !int_sck;
            next_div = int_sck ? SCK_LO_CYC - 1'b1 : SCK_HI_CYC - 1'b1;
          end else begin
            next_div = div - 1'b1;
          end
        end
        if (sck_rise) begin
          next_cnt = cnt + 1'b1;
          if (state == ST_WRITE) begin
            next_shreg = {shreg[WORD_W-2:0], din};
            if (next_cnt == WORD_BITS) begin
              next_wr_valid = 1'b1;
              next_wr.word = next_shreg;
              next_wr.to_data_cal = sel_frame;
              next_state = ST_DONE;
            end
          end
        end
        if (sck_fall && state == ST_READ && cnt != '0) begin
          if (cnt == WORD_BITS) begin
            next_state = ST_DONE;
          end else begin
            next_shreg = {shreg[WORD_W-2:0], 1'b0};
            next_sdata_out = shreg[WORD_W-2];
          end
        end
        // a strobe rising early abandons the word
        if ((state == ST_READ && rfs_n_s) || (state == ST_WRITE && tfs_n_s)) begin
          next_state = ST_IDLE;
          next_int_sck = 1'b1;
        end
      end
      ST_DONE: begin
        next_int_sck = 1'b1;
        if (rfs_n_s && tfs_n_s) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      shreg <= '0;
      cnt <= '0;
      div <= '0;
      int_sck <= 1'b1;
      sck_prev <= 1'b1;
      sel_frame <= 1'b0;
      sdata_out <= 1'b0;
      result_ready_n <= 1'b1;
      wr_valid <= 1'b0;
      wr <= '0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cnt <= next_cnt;
      div <= next_div;
      int_sck <= next_int_sck;
      sck_prev <= sck_lvl;
      sel_frame <= next_sel_frame;
      sdata_out <= next_sdata_out;
      result_ready_n <= next_ready_n;
      wr_valid <= next_wr_valid;
      wr <= next_wr;
    end
  end

  // pin drivers: clock driven only in self mode while a word is moving
  assign sclk_out = int_sck;
  assign sclk_oe_n = !(mode_self && active);
  assign sdata_oe_n = (state != ST_READ);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  a_self_drive_clk: assert property (mode_self && active
    |-> !sclk_oe_n ##[0:8] (!int_sck || !active))
    else $error("self clock not driven during transfer");
  a_sck_idle_high: assert property (!active |=> int_sck)
    else $error("self clock toggled without a strobe");
  a_release_done: assert property (word_done |=> sclk_oe_n && state == ST_DONE)
    else $error("clock pin not released after word");
  a_ext_input_only: assert property (!mode_self |-> sclk_oe_n)
    else $error("clock pin driven in external mode");
  a_count_on_rise: assert property (active && $past(active) && $changed(cnt)
    |-> $past(sck_rise) && cnt == $past(cnt) + 5'h01)
    else $error("bit count moved without a rising edge");
  a_ctrl_select: assert property (state == ST_IDLE && !rfs_n_s && !sel
    |=> state == ST_READ && shreg == $past(ctrl_word))
    else $error("control register not loaded");
  a_data_select: assert property (state == ST_IDLE && !rfs_n_s && sel && fifo_valid
    |=> shreg == $past(fifo_word) && sel_frame)
    else $error("data register not loaded");
  a_ready_release: assert property (res_pop |=> result_ready_n)
    else $error("result ready not raised after word read");
  a_out_on_fall: assert property (state == ST_READ && $past(state) == ST_READ
    && $changed(sdata_out) |-> $past(sck_fall))
    else $error("read data changed off a falling edge");

endmodule
`default_nettype wire

// ===== tb/adcsp_host_model.sv
// host serial port model: drives strobes, clock and write data, samples read data
`timescale 1ns/10ps
`default_nettype none
module adcsp_host_model import adcsp_pkg::*; (
  input wire logic clk,
  input wire logic self_mode,
  input wire logic sclk_out,
  input wire logic sclk_oe_n,
  input wire logic sdata_out,
  input wire logic sdata_oe_n,
  output logic pin,
  output logic rfs_n,
  output logic tfs_n,
  output logic sdata_in,
  output logic rel
);
  logic sclk_host;
  logic sdo;
  // a released data line is pulled high, so an early release shows as ones
  assign sdo = sdata_oe_n ? 1'b1 : sdata_out;
  // a released pin carries the host clock, whose idle level is high
  assign pin = sclk_oe_n ? sclk_host : sclk_out;
  initial begin
    sclk_host = 1'b1;
    rfs_n = 1'b1;
    tfs_n = 1'b1;
    sdata_in = 1'b0;
    rel = 1'b0;
  end
  // wait for a pin level, bounded so a dead clock cannot hang the host
  task automatic wait_pin(input logic v);
    int w;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (pin !== v && w < 300);
  endtask
  // one frame of nbits clock bits, with an optional pause after bit 11 under external clocking
  task automatic frame(input logic rd, input logic [WORD_W-1:0] wd, input int nbits,
                       input int gap, output logic [WORD_W-1:0] q);
    int i;
    q = '0;
    @(posedge clk);
    rfs_n <= !rd;
    tfs_n <= rd;
    if (!self_mode) begin
      repeat (6) @(posedge clk);
    end
    for (i = 0; i < nbits; i++) begin
      if (self_mode) begin
        wait_pin(1'b0);
        sdata_in <= wd[WORD_W-1-i];
        wait_pin(1'b1);
        q[WORD_W-1-i] = sdo;
      end else begin
        // low 5 and high 3 cycles keeps the clock at an eighth of clk
        sclk_host <= 1'b0;
        sdata_in <= wd[WORD_W-1-i];
        repeat (5) @(posedge clk);
        q[WORD_W-1-i] = sdo;
        sclk_host <= 1'b1;
        repeat (3 + ((i == 11) ? gap : 0)) @(posedge clk);
      end
    end
    // a whole read word needs one more falling edge before the strobe may rise
    if (nbits == WORD_W && !self_mode) begin
      sclk_host <= 1'b0;
      repeat (5) @(posedge clk);
    end
    i = 0;
    while (nbits == WORD_W && sclk_oe_n !== 1'b1 && i < 40) begin
      @(posedge clk);
      i++;
    end
    rel = (sclk_oe_n === 1'b1);
    rfs_n <= 1'b1;
    tfs_n <= 1'b1;
    repeat (2) @(posedge clk);
    sclk_host <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/adcsp_port_tb.sv
// self-checking bench of the converter serial host port
`timescale 1ns/10ps
`default_nettype none
module adcsp_port_tb;
  import adcsp_pkg::*;
  localparam logic [WORD_W-1:0] CTRL = 24'h3c5a96;
  logic clk, rst_n, clock_select, register_select, res_valid;
  logic [WORD_W-1:0] res_word;
  logic [WORD_W-1:0] ctrl_word;
  logic [WORD_W-1:0] q;
  logic pin, rfs_n, tfs_n, sdata_in, rel;
  logic sclk_out, sclk_oe_n, sdata_out, sdata_oe_n, result_ready_n, res_ready, wr_valid;
  adcsp_wr_t wr;
  int bad_count, total_checks;
  int wr_seen = 0;
  int drv = 0;
  int oe = 0;
  int rdy_up = 0;
  logic rdy_q = 1'b1;

  adcsp_port u_adcsp_port (.clk(clk), .rst_n(rst_n), .clock_select(clock_select),
    .register_select(register_select), .receive_frame_strobe_n(rfs_n),
    .transmit_frame_strobe_n(tfs_n), .sclk_in(pin), .sclk_out(sclk_out),
    .sclk_oe_n(sclk_oe_n), .sdata_in(sdata_in), .sdata_out(sdata_out),
    .sdata_oe_n(sdata_oe_n), .result_ready_n(result_ready_n), .res_valid(res_valid),
    .res_ready(res_ready), .res_word(res_word), .ctrl_word(ctrl_word),
    .wr_valid(wr_valid), .wr(wr));
  adcsp_host_model u_adcsp_host_model (.clk(clk), .self_mode(clock_select),
    .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sdata_out(sdata_out),
    .sdata_oe_n(sdata_oe_n), .pin(pin),
    .rfs_n(rfs_n), .tfs_n(tfs_n), .sdata_in(sdata_in), .rel(rel));

  // the system clock stands in for the master clock, supplied from outside
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // count write pulses, driven clock and data cycles, and rises of result ready
  always @(posedge clk) begin
    if (wr_valid === 1'b1) wr_seen <= wr_seen + 1;
    if (sclk_oe_n === 1'b0) drv <= drv + 1;
    if (sdata_oe_n === 1'b0) oe <= oe + 1;
    if (result_ready_n === 1'b1 && rdy_q === 1'b0) rdy_up <= rdy_up + 1;
    rdy_q <= result_ready_n;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [WORD_W-1:0] exp,
                     input logic [WORD_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // valid stays up across back-to-back pushes
  task automatic push_n(input logic [WORD_W-1:0] base, input int n);
    int k;
    int w;
    res_valid <= 1'b1;
    for (k = 0; k < n; k++) begin
      res_word <= base + WORD_W'(k);
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (res_ready !== 1'b1 && w < 50);
    end
    res_valid <= 1'b0;
  endtask
  task automatic set_mode(input logic m);
    @(posedge clk);
    clock_select <= m;
    repeat (4) @(posedge clk);
  endtask
  task automatic xfer(input logic rd, input logic sel, input logic [WORD_W-1:0] wd,
                      input int nbits, input int gap);
    @(posedge clk);
    register_select <= sel;
    repeat (2) @(posedge clk);
    u_adcsp_host_model.frame(rd, wd, nbits, gap, q);
  endtask
  // external clock: writes to both targets, one gated, then an aborted one
  task automatic t_ext_write;
    int n;
    int e;
    n = wr_seen;
    e = oe;
    set_mode(1'b0);
    xfer(1'b0, 1'b0, 24'ha5c33c, WORD_W, 0);
    chk("wr word", 24'ha5c33c, wr.word);
    chk("wr target", 24'h0, {23'h0, wr.to_data_cal});
    xfer(1'b0, 1'b1, 24'h5a0ff1, WORD_W, 30);
    chk("gated word", 24'h5a0ff1, wr.word);
    chk("gated target", 24'h1, {23'h0, wr.to_data_cal});
    xfer(1'b0, 1'b0, 24'h123456, 10, 0);
    chk("abort keeps", 24'h5a0ff1, wr.word);
    chk("write pulses", WORD_W'(n + 2), WORD_W'(wr_seen));
    chk("no data drive", WORD_W'(e), WORD_W'(oe));
  endtask
  // external clock reads: control register, a pending result, an empty buffer
  task automatic t_ext_read;
    int d;
    int e;
    d = drv;
    e = oe;
    xfer(1'b1, 1'b0, '0, WORD_W, 0);
    chk("ctrl read", CTRL, q);
    chk("data drive", 24'h1, {23'h0, oe - e >= WORD_W * 8});
    chk("data release", 24'h1, {23'h0, sdata_oe_n});
    push_n(24'h81f00e, 1);
    repeat (4) @(posedge clk);
    chk("ready low", 24'h0, {23'h0, result_ready_n});
    xfer(1'b1, 1'b1, '0, WORD_W, 0);
    chk("data read", 24'h81f00e, q);
    chk("ready high", 24'h1, {23'h0, result_ready_n});
    xfer(1'b1, 1'b1, '0, WORD_W, 0);
    chk("empty read", 24'h0, q);
    chk("no drive", 24'h1, {23'h0, drv == d});
  endtask
  // self clock: still while idle, driven in a frame, released at word end or abort
  task automatic t_self;
    int d;
    logic ok;
    set_mode(1'b1);
    push_n(24'hc30a71, 1);
    ok = 1'b1;
    repeat (20) begin
      @(posedge clk);
      ok = ok & (sclk_out === 1'b1) & (sclk_oe_n === 1'b1);
    end
    chk("idle clock", 24'h1, {23'h0, ok});
    d = drv;
    xfer(1'b1, 1'b1, '0, WORD_W, 0);
    chk("self read", 24'hc30a71, q);
    chk("self drive", 24'h1, {23'h0, drv - d >= WORD_W * 8});
    chk("word end release", 24'h1, {23'h0, rel});
    xfer(1'b0, 1'b0, 24'h0, 8, 0);
    chk("abort release", 24'h1, {23'h0, sclk_oe_n});
  endtask
  // fill the buffer until it refuses, then drain it with a pausing host
  task automatic t_fifo;
    int k;
    int u;
    set_mode(1'b0);
    push_n(24'h100000, FIFO_DEPTH);
    @(posedge clk);
    chk("full refuses", 24'h0, {23'h0, res_ready});
    u = rdy_up;
    for (k = 0; k < FIFO_DEPTH; k++) begin
      xfer(1'b1, 1'b1, '0, WORD_W, 10);
      chk("drained word", 24'h100000 + WORD_W'(k), q);
    end
    chk("empty flag", 24'h1, {23'h0, result_ready_n});
    chk("ready pulses", WORD_W'(FIFO_DEPTH), WORD_W'(rdy_up - u));
  endtask
  initial begin
    rst_n = 1'b0;
    clock_select = 1'b0;
    register_select = 1'b0;
    res_valid = 1'b0;
    res_word = '0;
    ctrl_word = CTRL;
    bad_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_ext_write;
    t_ext_read;
    t_self;
    t_fifo;
    complete_run;
  end
  // watchdog sized at several times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
